// ===== rtl/udc_pkg.sv
package udc_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned NCH          = 4;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned FIFO_DEPTH_D = 8;
  localparam int unsigned REC_W        = 13;

  // ==========================================================
  // I/O port map
  localparam logic [11:0] ADDR_STAT_CMD = 12'h00d0;
  localparam logic [11:0] ADDR_SOFT_REQ = 12'h00d2;
  localparam logic [11:0] ADDR_MASK     = 12'h00d4;
  localparam logic [11:0] ADDR_MODE     = 12'h00d6;

  // ==========================================================
  // Command register fields
  localparam int unsigned CMD_DACK_LOW = 7;
  localparam int unsigned CMD_DREQ_LOW = 6;
  localparam int unsigned CMD_EXT_WR   = 5;
  localparam int unsigned CMD_ROTATE   = 4;
  localparam int unsigned CMD_COMPRESS = 3;
  localparam int unsigned CMD_ENABLE   = 2;

  // ==========================================================
  // Mask and mode write fields
  localparam int unsigned SEL_MSB      = 1;
  localparam int unsigned SEL_LSB      = 0;
  localparam int unsigned MASK_SET_BIT = 2;
  localparam int unsigned MODE_MSB     = 7;
  localparam int unsigned MODE_LSB     = 2;

  // Stored per-channel mode, written bits 7:2 shifted down by two
  localparam int unsigned MD_XMODE_MSB = 5;
  localparam int unsigned MD_XMODE_LSB = 4;
  localparam int unsigned MD_DEC       = 3;
  localparam int unsigned MD_AUTO      = 2;
  localparam int unsigned MD_TYPE_MSB  = 1;
  localparam int unsigned MD_TYPE_LSB  = 0;

  // ==========================================================
  // Status register fields: channel index i (1 to 3) sits at i and 4+i; bits 0 and 4 stay zero
  localparam int unsigned STAT_TC_LSB  = 0;
  localparam int unsigned STAT_REQ_LSB = 4;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CMD_RST  = 8'h00;
  localparam logic [3:0] MASK_RST = 4'hf;
  localparam logic [5:0] MODE_RST = 6'h00;

  // ==========================================================
  // Transfer timing in clock cycles
  localparam logic [2:0] CYC_NORMAL = 3'h4;
  localparam logic [2:0] CYC_COMP   = 3'h2;
  localparam logic [2:0] CNT_LAST   = 3'h1;
  localparam logic [2:0] CNT_ONE    = 3'h1;

  typedef enum logic [1:0] {
    XM_DEMAND, XM_SINGLE, XM_BLOCK, XM_CASCADE
  } udc_xmode_t;

  typedef enum logic [1:0] {
    XT_VERIFY, XT_MEMRD, XT_MEMWR, XT_RSVD
  } udc_xtype_t;

endpackage

// ===== rtl/udc_fifo.sv
`timescale 1ns/1ps
module udc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ==========================================================
  // Elaboration check
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("udc_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } udc_fifo_st_t;

  udc_fifo_st_t st_ff;
  udc_fifo_st_t nxt_st;
  logic         full;
  logic         empty;

  // ==========================================================
  // Pointers carry one wrap bit so full and empty stay distinct
  assign full      = (st_ff.wp[AW] != st_ff.rp[AW]) &&
                     (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
  assign empty     = (st_ff.wp == st_ff.rp);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_ff.mem[st_ff.rp[AW-1:0]];

  always_comb begin
    nxt_st = st_ff;
    if (in_valid && !full) begin
      nxt_st.mem[st_ff.wp[AW-1:0]] = in_data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ===== rtl/udc_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01: Status bits 3,2,1 show terminal count of channels 7,6,5; bits 4,0 zero.
// RULE_02: Command bit 7 sets acknowledge polarity: 0 active high, 1 active low.
// RULE_03: Command bit 6 sets request polarity: 0 active high, 1 active low.
// RULE_04: Command bit 5 picks late write (0) or extended write (1) strobe.
// RULE_05: Command bit 4 picks fixed (0) or rotating (1) channel priority.
// RULE_06: Command bit 3 picks normal (0) or compressed (1) transfer timing.
// RULE_07: Command bit 2 enables channels 7-4; when zero no transfers happen.
// RULE_08: Software writes zero to command bits 1 and 0.
// RULE_09: Software request writes are accepted but never start a transfer.
// RULE_10: Software request: bit 2 set/reset, bits 1:0 pick 5-7, never 00.
// RULE_11: Mask write sets the chosen mask if bit 2 is one, else clears it.
// RULE_12: Mask write bits 1:0 pick channel 4,5,6,7 by codes 00 to 11.
// RULE_13: Mode bits 7:6 pick demand, single, block or cascade transfer mode.
// RULE_14: Mode bit 5 picks address increment (0) or decrement (1).
// RULE_15: Mode bit 4 enables address and count reload after terminal count.
// RULE_16: Mode bits 3:2: verify, memory read, memory write; 11 is reserved.
// RULE_17: Status bits 7,6,5 show pending requests of channels 7,6,5.
// RULE_18: Software programs channel 4 as cascade; reset leaves it otherwise.
// RULE_19: Mask and mode writes change only the selected channel.
module udc_ctrl
  import udc_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = udc_pkg::FIFO_DEPTH_D
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [11:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  output logic      [7:0]  io_rdata,
  input  wire logic [3:0]  dreq_pin,
  output logic      [3:0]  dack_pin,
  input  wire logic [3:0]  term_count,
  output logic      [3:0]  reload_ch,
  input  wire logic [7:0]  dev_data,
  output logic             wr_strobe,
  output logic             mem_valid,
  input  wire logic        mem_ready,
  output logic      [1:0]  mem_chan,
  output logic      [1:0]  mem_type,
  output logic             mem_dec,
  output logic      [7:0]  mem_data
);
  import udc_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_CASC} udc_state_t;

  typedef struct packed {
    logic [3:0]      s1;
    logic [3:0]      s2;
    logic [3:0]      s3;
    logic [3:0]      req;
    logic [7:0]      cmd;
    logic [3:0]      mask;
    logic [3:0][5:0] mode;
    logic [3:0]      tc;
    logic [1:0]      prio;
    udc_state_t      state;
    logic [1:0]      ch;
    logic [2:0]      cnt;
    logic [3:0]      reload;
    logic [7:0]      rdata;
  } udc_st_t;

  udc_st_t              st_ff;
  udc_st_t              nxt_st;
  logic [3:0]           active;
  logic [3:0]           elig;
  logic [2:0]           found;
  logic [5:0]           cur_mode;
  udc_xmode_t           cur_xmode;
  udc_xtype_t           cur_type;
  logic [2:0]           cyc;
  logic                 last;
  logic                 done;
  logic                 push;
  logic                 fifo_ready;
  logic [REC_W-1:0]     rec_out;
  logic [3:0]           gnt;

  // ==========================================================
  // Arbitration helper: first requester starting from slot s
  function automatic logic [2:0] pick(input logic [3:0] r,
                                      input logic [1:0] s);
    logic [1:0] j;
    pick = '0;
    for (int i = 3; i >= 0; i--) begin
      j = 2'(s + 2'(i));
      if (r[j]) pick = {1'b1, j};
    end
  endfunction

  // ==========================================================
  // Request qualification
  assign active    = st_ff.req ^ {4{st_ff.cmd[CMD_DREQ_LOW]}};   // [RULE_03]
  assign elig      = active & ~st_ff.mask &
                     {4{st_ff.cmd[CMD_ENABLE]}};            // [RULE_07] [RULE_11]
  assign found     = pick(elig, st_ff.cmd[CMD_ROTATE] ?
                          st_ff.prio : 2'h0);                      // [RULE_05]
  assign cur_mode  = st_ff.mode[st_ff.ch];
  assign cur_xmode = udc_xmode_t'(cur_mode[MD_XMODE_MSB:MD_XMODE_LSB]);
  assign cur_type  = udc_xtype_t'(cur_mode[MD_TYPE_MSB:MD_TYPE_LSB]);
  assign cyc       = st_ff.cmd[CMD_COMPRESS] ? CYC_COMP :
                     CYC_NORMAL;                                   // [RULE_06]
  assign last      = (st_ff.state == ST_XFER) && (st_ff.cnt == CNT_LAST);
  // A full FIFO stretches the last cycle instead of dropping the word
  assign done      = last && (cur_type == XT_VERIFY || fifo_ready);
  assign push      = done && (cur_type != XT_VERIFY);              // [RULE_16]

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.reload = '0;
    nxt_st.s1     = dreq_pin;
    nxt_st.s2     = st_ff.s1;
    nxt_st.s3     = st_ff.s2;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.req = st_ff.s3;
    end

    // ========================================================
    // Register writes
    if (io_wr) begin
      if (io_addr == ADDR_STAT_CMD) begin
        nxt_st.cmd = io_wdata;                                     // [RULE_08]
      end else if (io_addr == ADDR_SOFT_REQ) begin
        nxt_st.cmd = st_ff.cmd;                          // [RULE_09] [RULE_10]
      end else if (io_addr == ADDR_MASK) begin
        nxt_st.mask[io_wdata[SEL_MSB:SEL_LSB]] =
          io_wdata[MASK_SET_BIT];                      // [RULE_11] [RULE_12]
      end else if (io_addr == ADDR_MODE) begin
        nxt_st.mode[io_wdata[SEL_MSB:SEL_LSB]] =
          io_wdata[MODE_MSB:MODE_LSB];       // [RULE_13] [RULE_14] [RULE_19]
      end
    end

    // ========================================================
    // Register reads; reading status clears the sticky counts
    if (io_rd) begin
      if (io_addr == ADDR_STAT_CMD) begin
        nxt_st.rdata = '0;
        nxt_st.rdata[STAT_REQ_LSB+1 +: 3] = active[3:1];           // [RULE_17]
        nxt_st.rdata[STAT_TC_LSB+1 +: 3]  = st_ff.tc[3:1];         // [RULE_01]
        nxt_st.tc = '0;
      end else if (io_addr == ADDR_MASK) begin
        nxt_st.rdata = {4'h0, st_ff.mask};
      end else begin
        nxt_st.rdata = '0;
      end
    end

    // ========================================================
    // Service sequencer
    case (st_ff.state)
      ST_IDLE: begin
        if (found[2]) begin
          nxt_st.ch = found[1:0];
          if (st_ff.mode[found[1:0]][MD_XMODE_MSB:MD_XMODE_LSB] ==
              XM_CASCADE) begin
            nxt_st.state = ST_CASC;                                // [RULE_13]
          end else begin
            nxt_st.state = ST_XFER;
            nxt_st.cnt   = cyc;                                    // [RULE_06]
          end
        end
      end
      ST_XFER: begin
        if (!last) begin
          nxt_st.cnt = st_ff.cnt - CNT_ONE;
        end else if (done) begin
          if (st_ff.cmd[CMD_ROTATE]) begin
            nxt_st.prio = 2'(st_ff.ch + 2'h1);                     // [RULE_05]
          end
          if (term_count[st_ff.ch]) begin
            // Set wins over a status-read clear in the same cycle
            nxt_st.tc[st_ff.ch] = 1'b1;
            if (cur_mode[MD_AUTO]) begin
              nxt_st.reload[st_ff.ch] = 1'b1;                      // [RULE_15]
            end else begin
              nxt_st.mask[st_ff.ch] = 1'b1;
            end
            nxt_st.state = ST_IDLE;
          end else if ((cur_xmode == XM_DEMAND && elig[st_ff.ch]) ||
                       (cur_xmode == XM_BLOCK && st_ff.cmd[CMD_ENABLE] &&
                        !st_ff.mask[st_ff.ch])) begin              // [RULE_13]
            nxt_st.cnt = cyc;
          end else begin
            nxt_st.state = ST_IDLE;
          end
        end
      end
      ST_CASC: begin
        if (!elig[st_ff.ch]) begin
          nxt_st.state = ST_IDLE;                                  // [RULE_07]
        end
      end
      default: begin
        nxt_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff      <= '0;
      st_ff.cmd  <= CMD_RST;
      st_ff.mask <= MASK_RST;
      st_ff.mode <= {4{MODE_RST}};                                 // [RULE_18]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign gnt       = (st_ff.state == ST_IDLE) ? 4'h0 : (4'h1 << st_ff.ch);
  assign dack_pin  = gnt ^ {4{st_ff.cmd[CMD_DACK_LOW]}};           // [RULE_02]
  assign wr_strobe = (st_ff.state == ST_XFER) &&
                     (cur_type != XT_VERIFY) &&
                     (st_ff.cmd[CMD_EXT_WR] || last);              // [RULE_04]
  assign io_rdata  = st_ff.rdata;
  assign reload_ch = st_ff.reload;
  assign mem_chan  = rec_out[12:11];
  assign mem_type  = rec_out[10:9];
  assign mem_dec   = rec_out[8];
  assign mem_data  = rec_out[7:0];

  // Direction travels with each word so the address side never looks back
  udc_fifo #(
    .WIDTH (REC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (ref_clk),
    .rst       (rst),
    .in_valid  (push),
    .in_data   ({st_ff.ch, cur_type, cur_mode[MD_DEC],
                 dev_data}),                                       // [RULE_14]
    .in_ready  (fifo_ready),
    .out_valid (mem_valid),
    .out_data  (rec_out),
    .out_ready (mem_ready)
  );

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  function automatic logic [3:0][5:0] keep(input logic [1:0] s);
    keep    = {4{6'h3f}};
    keep[s] = 6'h00;
  endfunction

  sequence xfer_start_s;
    st_ff.state == ST_IDLE && nxt_st.state == ST_XFER;
  endsequence

  sequence single_done_s;
    done && cur_xmode == XM_SINGLE;
  endsequence

  dack_idle_pol_a: assert property (                               // [RULE_02]
    st_ff.state == ST_IDLE |-> dack_pin == {4{st_ff.cmd[CMD_DACK_LOW]}})
    else $error("acknowledge not at its inactive level while idle");

  dreq_pol_a: assert property (                                    // [RULE_03]
    st_ff.state == ST_IDLE &&
    (st_ff.req ^ {4{st_ff.cmd[CMD_DREQ_LOW]}}) == 4'h0
    |=> st_ff.state == ST_IDLE)
    else $error("service started without an active request");

  late_write_a: assert property (                                  // [RULE_04]
    st_ff.state == ST_XFER && cur_type != XT_VERIFY
    |-> wr_strobe == (st_ff.cmd[CMD_EXT_WR] || st_ff.cnt == CNT_LAST))
    else $error("write strobe shape wrong");

  fixed_prio_a: assert property (                                  // [RULE_05]
    st_ff.state == ST_IDLE && !st_ff.cmd[CMD_ROTATE] && elig[0]
    |=> st_ff.ch == 2'h0 && st_ff.state != ST_IDLE)
    else $error("fixed priority did not pick channel 4");

  timing_mode_a: assert property (                                 // [RULE_06]
    xfer_start_s |=> st_ff.cnt ==
      ($past(st_ff.cmd[CMD_COMPRESS]) ? CYC_COMP : CYC_NORMAL))
    else $error("transfer length does not follow timing mode");

  global_off_a: assert property (                                  // [RULE_07]
    st_ff.state == ST_IDLE && !st_ff.cmd[CMD_ENABLE] &&
    !(io_wr && io_addr == ADDR_STAT_CMD && io_wdata[CMD_ENABLE])
    |=> st_ff.state == ST_IDLE [*2])
    else $error("transfer started while channels disabled");

  soft_req_a: assert property (                                    // [RULE_09]
    io_wr && io_addr == ADDR_SOFT_REQ |=> st_ff.cmd == $past(st_ff.cmd))
    else $error("software request write changed controller state");

  mask_write_a: assert property (                       // [RULE_11] [RULE_12]
    io_wr && io_addr == ADDR_MASK && io_wdata[MASK_SET_BIT]
    |=> st_ff.mask[$past(io_wdata[SEL_MSB:SEL_LSB])])
    else $error("mask write did not set the chosen channel");

  mode_keep_a: assert property (                        // [RULE_13] [RULE_19]
    io_wr && io_addr == ADDR_MODE
    |=> st_ff.mode[$past(io_wdata[SEL_MSB:SEL_LSB])] ==
          $past(io_wdata[MODE_MSB:MODE_LSB]) &&
        (st_ff.mode & keep($past(io_wdata[SEL_MSB:SEL_LSB]))) ==
          ($past(st_ff.mode) & keep($past(io_wdata[SEL_MSB:SEL_LSB]))))
    else $error("mode write wrong or touched another channel");

  single_mode_a: assert property (                                 // [RULE_13]
    single_done_s |=> st_ff.state == ST_IDLE)
    else $error("single mode kept the channel");

  auto_init_a: assert property (                                   // [RULE_15]
    done && term_count[st_ff.ch] && cur_mode[MD_AUTO]
    |=> reload_ch[$past(st_ff.ch)] ##1 reload_ch == 4'h0)
    else $error("auto-initialize reload pulse missing");

  verify_nodata_a: assert property (                               // [RULE_16]
    st_ff.state == ST_XFER && cur_type == XT_VERIFY |-> !push)
    else $error("verify transfer moved data");

  status_read_a: assert property (                      // [RULE_01] [RULE_17]
    io_rd && io_addr == ADDR_STAT_CMD
    |=> io_rdata[3:1] == $past(st_ff.tc[3:1]) &&
        io_rdata[7:5] == $past(active[3:1]) &&
        io_rdata[4] == 1'b0 && io_rdata[0] == 1'b0)
    else $error("status read returned wrong bits");

endmodule

// ===== test/udc_periph.sv
`timescale 1ns/1ps
// ==========
// Peripheral side: raises requests, withdraws them once served
module udc_periph (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [3:0] want,
  input  wire logic       oneshot,
  input  wire logic       tc_en,
  input  wire logic       req_low,
  input  wire logic       ack_low,
  input  wire logic [7:0] val,
  input  wire logic [3:0] dack_pin,
  output logic      [3:0] dreq_pin,
  output logic      [3:0] term_count,
  output logic      [7:0] dev_data
);
  logic [3:0] served_ff;
  logic [3:0] ack;

  assign ack = dack_pin ^ {4{ack_low}};
  // A served device drops its request; cascade holds it until told
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      served_ff <= 4'h0;
    end else begin
      served_ff <= (served_ff | (oneshot ? ack : 4'h0)) & want;
    end
  end
  assign dreq_pin   = (want & ~served_ff) ^ {4{req_low}};
  assign term_count = tc_en ? ack : 4'h0;
  // Off acknowledge the data bus shows garbage, never the last value
  assign dev_data   = (ack != 4'h0) ? val : ~val;
endmodule

// ===== test/upper_dma_channel_control_tb.sv
`timescale 1ns/1ps
module upper_dma_channel_control_tb;
  import udc_pkg::*;
  logic        ref_clk, rst, io_wr, io_rd, mem_ready, oneshot, tc_en;
  logic [11:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, dev_data, mem_data, val, cmd, rd_v, cv;
  logic [3:0]  dreq_pin, dack_pin, term_count, reload_ch;
  logic [3:0]  want, act, first, rl, mask_m;
  logic [1:0]  mem_chan, mem_type, ch, ty, xm;
  logic        mem_valid, mem_dec, wr_strobe, dec;
  logic [12:0] rec;
  int          n_errors, checks_done, n_rec, dack_cyc, wstr_cyc, len;

  always #10 ref_clk = ~ref_clk;
  assign act = dack_pin ^ {4{cmd[7]}};

  udc_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .dreq_pin(dreq_pin), .dack_pin(dack_pin), .term_count(term_count),
    .reload_ch(reload_ch), .dev_data(dev_data), .wr_strobe(wr_strobe),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_chan(mem_chan),
    .mem_type(mem_type), .mem_dec(mem_dec), .mem_data(mem_data));

  udc_periph i_periph (.ref_clk(ref_clk), .rst(rst), .want(want),
    .oneshot(oneshot), .tc_en(tc_en), .req_low(cmd[6]), .ack_low(cmd[7]),
    .val(val), .dack_pin(dack_pin), .dreq_pin(dreq_pin),
    .term_count(term_count), .dev_data(dev_data));

  // ==========
  // Monitor
  always @(posedge ref_clk) begin
    if (mem_valid && mem_ready) begin
      n_rec++;
      rec = {mem_chan, mem_type, mem_dec, mem_data};
    end
    if (act != 4'h0) dack_cyc++;
    if (wr_strobe) wstr_cyc++;
    if (first == 4'h0) first = act;
    rl = rl | reload_ch;
  end

  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [12:0] e,
                     input logic [12:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    if (a == ADDR_STAT_CMD) cmd = d;
    @(posedge ref_clk);
    #1;
    io_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    io_rd = 1'b0;
    rd_v = io_rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic clr();
    n_rec = 0;
    dack_cyc = 0;
    wstr_cyc = 0;
    first = 4'h0;
    rl = 4'h0;
  endtask

  // Bounded wait for one grant to start and finish
  task automatic done_wait();
    for (int k = 0; k < 60; k++) begin
      @(posedge ref_clk);
      if (dack_cyc > 0 && act == 4'h0) break;
    end
    idle(3);
  endtask

  // Strobe cycles per transfer: none for verify, one for late write
  function automatic int exp_strb(input logic [1:0] t, input logic e,
                                  input int n);
    return (t == 2'h0) ? 0 : (e ? n : 1);
  endfunction

  task automatic endt(input string s);
    $display("test %s done, mismatches so far %0d", s, n_errors);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========
  // Tests
  initial begin
    rst = 1'b1; ref_clk = 1'b0; io_addr = 12'h000; io_wdata = 8'h00;
    io_wr = 1'b0; io_rd = 1'b0; mem_ready = 1'b1; want = 4'h0;
    oneshot = 1'b1; tc_en = 1'b1; val = 8'h00; cmd = 8'h00;
    mask_m = 4'hf; n_errors = 0; checks_done = 0;
    clr();
    void'($urandom(57));
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    rd(ADDR_STAT_CMD); chk("status", 8'h00, rd_v);
    rd(ADDR_MASK); chk("mask rst", 8'h0f, rd_v);
    rd(ADDR_SOFT_REQ); chk("softreq rd", 8'h00, rd_v);
    rd(12'h1ff); chk("unmapped", 8'h00, rd_v);
    endt("reset");
    for (int k = 0; k < 20; k++) begin
      rd_v = 8'($urandom);
      wr(ADDR_MASK, {5'h00, rd_v[2:0]});
      mask_m[rd_v[1:0]] = rd_v[2];
      rd(ADDR_MASK); chk("mask", {4'h0, mask_m}, rd_v);
    end
    for (int k = 0; k < 4; k++) wr(ADDR_MASK, 8'(4 + k));
    endt("mask");
    // Disabled controller: request pending, soft requests, no grant
    wr(ADDR_STAT_CMD, 8'h00);
    wr(ADDR_MASK, 8'h01);
    clr();
    want = 4'b0010;
    for (int k = 1; k < 4; k++) wr(ADDR_SOFT_REQ, 8'(4 + k));
    idle(20);
    chk("no grant", 0, dack_cyc);
    rd(ADDR_STAT_CMD); chk("status req", 8'h20, rd_v);
    want = 4'h0;
    wr(ADDR_MASK, 8'h05);
    idle(6);
    endt("disable");
    for (int k = 0; k < 12; k++) begin
      ch = 2'($urandom_range(3, 1));
      ty = 2'(k % 3);
      xm = 2'(k % 2);
      dec = 1'($urandom);
      val = 8'($urandom);
      cv = {3'($urandom), 1'b0, 1'($urandom), 3'b100};
      len = cv[3] ? 2 : 4;
      wr(ADDR_STAT_CMD, cv);
      idle(6);
      wr(ADDR_MODE, {xm, dec, 1'b0, ty, ch});
      wr(ADDR_MASK, {6'h00, ch});
      chk("dack idle", {4{cv[7]}}, dack_pin);
      clr();
      want[ch] = 1'b1;
      done_wait();
      chk("dack len", len, dack_cyc);
      chk("strobe", exp_strb(ty, cv[5], len), wstr_cyc);
      chk("records", ty == 0 ? 0 : 1, n_rec);
      if (ty != 0) chk("record", {ch, ty, dec, val}, rec);
      rd(ADDR_STAT_CMD); chk("tc", 8'(1 << ch), rd_v);
      rd(ADDR_MASK); chk("tc mask", 8'h0f, rd_v);
      want = 4'h0;
    end
    endt("transfer");
    for (int r = 0; r < 2; r++) begin
      wr(ADDR_STAT_CMD, r ? 8'h14 : 8'h04);
      wr(ADDR_MODE, 8'h4a);
      wr(ADDR_MODE, 8'h49);
      wr(ADDR_MODE, 8'h4b);
      wr(ADDR_MASK, 8'h02);
      clr();
      want = 4'b0100;
      done_wait();
      want = 4'h0;
      wr(ADDR_MASK, 8'h01);
      wr(ADDR_MASK, 8'h03);
      clr();
      want = 4'b1010;
      idle(40);
      chk("first grant", r ? 4'b1000 : 4'b0010, first);
      chk("both served", 2, n_rec);
      want = 4'h0;
      rd(ADDR_STAT_CMD);
    end
    endt("priority");
    wr(ADDR_MODE, 8'h57);
    wr(ADDR_MASK, 8'h03);
    clr();
    want = 4'b1000;
    done_wait();
    want = 4'h0;
    chk("reload", 4'b1000, rl);
    rd(ADDR_MASK); chk("auto mask", 8'h07, rd_v);
    wr(ADDR_MASK, 8'h07);
    rd(ADDR_STAT_CMD);
    endt("autoinit");
    // Block mode into a stalled drain: eight queued, ninth held
    wr(ADDR_MODE, 8'h89);
    mem_ready = 1'b0;
    tc_en = 1'b0;
    clr();
    wr(ADDR_MASK, 8'h01);
    want = 4'b0010;
    idle(80);
    chk("stall", 2'b11, {mem_valid, act[1]});
    tc_en = 1'b1;
    mem_ready = 1'b1;
    idle(40);
    chk("drained", 9, n_rec);
    want = 4'h0;
    endt("fifo");
    wr(ADDR_STAT_CMD, 8'h04);
    wr(ADDR_MODE, 8'hc0);
    oneshot = 1'b0;
    wr(ADDR_MASK, 8'h00);
    want = 4'b0001;
    idle(30);
    chk("cascade hold", 1, act[0]);
    want = 4'h0;
    idle(10);
    chk("cascade drop", 0, act[0]);
    endt("cascade");
    finish_test();
  end

  // Whole run is under a thousand cycles; this 10000-cycle limit is over ten times that
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule
